//--- verilog/lcdic_map.vh
// lcdic_map.vh - register offsets, field positions, reset values and timing
// assumes: included by the lcdic core module by bare name
`ifndef LCDIC_MAP_VH
`define LCDIC_MAP_VH

// ----------------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------------
`define LCDIC_OFS_INSTR   4'h0
`define LCDIC_OFS_DATA    4'h4
`define LCDIC_OFS_STATUS  4'h8
`define LCDIC_OFS_FLAGS   4'hc

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define LCDIC_ST_BUSY     7

// ----------------------------------------------------------------------
// flags register fields
// ----------------------------------------------------------------------
`define LCDIC_FL_SHIFT    0
`define LCDIC_FL_INCR     1
`define LCDIC_FL_BLINK    2
`define LCDIC_FL_CURSOR   3
`define LCDIC_FL_DISP     4
`define LCDIC_FL_EXT      5
`define LCDIC_FL_WIDTH    6
`define LCDIC_FL_SCROLL   7
`define LCDIC_FL_AWAKE    8
`define LCDIC_FL_GRAPH    9
`define LCDIC_FL_INVSEL   10
`define LCDIC_FL_INVLN    12
`define LCDIC_FL_WIN      16

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LCDIC_RST_INCR    1'b1
`define LCDIC_RST_SHIFT   1'b0
`define LCDIC_RST_DISP    1'b0
`define LCDIC_RST_CURSOR  1'b0
`define LCDIC_RST_BLINK   1'b0
`define LCDIC_RST_WIDTH   1'b1
`define LCDIC_RST_EXT     1'b0
`define LCDIC_RST_SCROLL  1'b0
`define LCDIC_RST_INVSEL  2'h0
`define LCDIC_RST_INVLN   4'h0
`define LCDIC_RST_AWAKE   1'b1
`define LCDIC_RST_GRAPH   1'b0
`define LCDIC_RST_AC      7'h00

// ----------------------------------------------------------------------
// ram contents and timing
// ----------------------------------------------------------------------
`define LCDIC_SPACE_CODE  8'h20
`define LCDIC_HOME_AC     7'h00
`define LCDIC_CLK_MHZ     200
`define LCDIC_T_CLEAR_US  1600
`define LCDIC_T_SHORT_US  72
`define LCDIC_CYC_CLEAR   (`LCDIC_T_CLEAR_US * `LCDIC_CLK_MHZ)
`define LCDIC_CYC_SHORT   (`LCDIC_T_SHORT_US * `LCDIC_CLK_MHZ)

`endif

//--- verilog/lcdic_text_ram.v
// lcdic_text_ram.v - character ram, one write port, registered read port
// assumes: single clock, clock enable freezes writes and the read register
`timescale 1ns/10ps
module lcdic_text_ram #(
	parameter AW = 7,
	parameter DW = 8
) (
	input  wire          pclk,
	input  wire          clk_en,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	input  wire [AW-1:0] raddr,
	output reg  [DW-1:0] rdata_ff
);

reg [DW-1:0] mem [0:(1<<AW)-1];

always @(posedge pclk) begin
	if (clk_en) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_ff <= mem[raddr];
	end
end

endmodule

//--- verilog/lcdic_busy_timer.v
// lcdic_busy_timer.v - execution-time down counter behind the pending flag
// assumes: start is a one-cycle pulse from the instruction decoder
`timescale 1ns/10ps
module lcdic_busy_timer #(
	parameter CW = 20
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          clk_en,
	input  wire          start,
	input  wire [CW-1:0] load_val,
	output wire          busy
);

reg [CW-1:0] cnt_ff;

assign busy = (cnt_ff != {CW{1'b0}});

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt_ff <= {CW{1'b0}};
	end else if (clk_en) begin
		if (start) begin
			cnt_ff <= load_val;
		end else if (busy) begin
			cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
		end
	end
end

endmodule

//--- verilog/lcdic_core.v
// lcdic_core.v - instruction interpreter of the dot-matrix display controller
// assumes: apb master on pclk; char ram and busy timer instantiated here
`timescale 1ns/10ps
`include "lcdic_map.vh"
module lcdic_core #(
	parameter AW         = 12,
	parameter ACW        = 7,
	parameter CW         = 20,
	parameter CYC_CLEAR  = `LCDIC_CYC_CLEAR,
	parameter CYC_SHORT  = `LCDIC_CYC_SHORT
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          clk_en,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [AW-1:0] paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	output reg           disp_on,
	output reg           cursor_on,
	output reg           blink_on,
	output reg           graphic_on,
	output reg           awake,
	output reg  [3:0]    inverted_lines,
	output reg  [ACW-1:0] window_ofs
);

// ----------------------------------------------------------------------
// state
// ----------------------------------------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_FILL = 2'b10;

reg [1:0]     state_ff;
reg [ACW-1:0] addr_counter_ff;
reg [ACW-1:0] fill_addr_ff;
reg           incr_dir_ff;
reg           shift_en_ff;
reg           bus_width_select_ff;
reg           ext_set_select_ff;
reg           scroll_target_select_ff;
reg [1:0]     invert_sel_ff;

wire          busy_cnt;
wire          op_pending_flag;
wire [7:0]    ram_rdata;
wire          acc_done;
wire          addr_ok;
wire          wr_instr;
wire          wr_data;
wire          rd_data;
wire          accept_instr;
wire          accept_data;
wire [7:0]    ins;
wire          is_clear;
wire          is_home;
wire          is_entry;
reg           timer_start;
reg  [CW-1:0] timer_load;
reg           ram_we;
reg  [ACW-1:0] ram_waddr;
reg  [7:0]    ram_wdata;
reg  [31:0]   nxt_rdata;
reg  [ACW-1:0] ac_step;
reg  [ACW-1:0] win_step;

localparam [CW-1:0] LOAD_CLEAR = CYC_CLEAR[CW-1:0];
localparam [CW-1:0] LOAD_SHORT = CYC_SHORT[CW-1:0];
localparam [ACW-1:0] ONE_AC    = {{(ACW-1){1'b0}}, 1'b1};

// ----------------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------------
assign acc_done = psel & penable & pready;
assign addr_ok  = (paddr[AW-1:4] == {(AW-4){1'b0}}) & (paddr[1:0] == 2'b00);
assign wr_instr = acc_done & pwrite & addr_ok & (paddr[3:0] == `LCDIC_OFS_INSTR);
assign wr_data  = acc_done & pwrite & addr_ok & (paddr[3:0] == `LCDIC_OFS_DATA);
assign rd_data  = acc_done & ~pwrite & addr_ok & (paddr[3:0] == `LCDIC_OFS_DATA);
assign ins      = pwdata[7:0];

// fill keeps the flag up even if the timer ran out first
assign op_pending_flag = busy_cnt | state_ff[1];
assign accept_instr    = wr_instr & ~op_pending_flag;
assign accept_data     = (wr_data | rd_data) & ~op_pending_flag;

// ----------------------------------------------------------------------
// basic-set instruction classes
// ----------------------------------------------------------------------
assign is_clear = ~ext_set_select_ff & (ins == 8'h01);
assign is_home  = ~ext_set_select_ff & (ins[7:1] == 7'h01);
assign is_entry = ~ext_set_select_ff & (ins[7:2] == 6'h01);

// ----------------------------------------------------------------------
// readback mux
// ----------------------------------------------------------------------
always @* begin
	nxt_rdata = 32'h0000_0000;
	case (paddr[3:0])
	`LCDIC_OFS_DATA: begin
		nxt_rdata[7:0] = ram_rdata;
	end
	`LCDIC_OFS_STATUS: begin
		nxt_rdata[ACW-1:0]        = addr_counter_ff;
		nxt_rdata[`LCDIC_ST_BUSY] = op_pending_flag;
	end
	`LCDIC_OFS_FLAGS: begin
		nxt_rdata[`LCDIC_FL_SHIFT]  = shift_en_ff;
		nxt_rdata[`LCDIC_FL_INCR]   = incr_dir_ff;
		nxt_rdata[`LCDIC_FL_BLINK]  = blink_on;
		nxt_rdata[`LCDIC_FL_CURSOR] = cursor_on;
		nxt_rdata[`LCDIC_FL_DISP]   = disp_on;
		nxt_rdata[`LCDIC_FL_EXT]    = ext_set_select_ff;
		nxt_rdata[`LCDIC_FL_WIDTH]  = bus_width_select_ff;
		nxt_rdata[`LCDIC_FL_SCROLL] = scroll_target_select_ff;
		nxt_rdata[`LCDIC_FL_AWAKE]  = awake;
		nxt_rdata[`LCDIC_FL_GRAPH]  = graphic_on;
		nxt_rdata[`LCDIC_FL_INVSEL+1:`LCDIC_FL_INVSEL] = invert_sel_ff;
		nxt_rdata[`LCDIC_FL_INVLN+3:`LCDIC_FL_INVLN]   = inverted_lines;
		nxt_rdata[`LCDIC_FL_WIN+ACW-1:`LCDIC_FL_WIN]   = window_ofs;
	end
	default: begin
		nxt_rdata = 32'h0000_0000;
	end
	endcase
	if (!addr_ok) begin
		nxt_rdata = 32'h0000_0000;
	end
end

// ----------------------------------------------------------------------
// execution time and ram port
// ----------------------------------------------------------------------
always @* begin
	timer_start = accept_instr | accept_data;
	timer_load  = LOAD_SHORT;
	if (accept_instr && is_clear) begin
		timer_load = LOAD_CLEAR;
	end
	// fill runs one word a cycle; the pending flag stays up through it whatever the clear load
	ram_we    = state_ff[1] | (accept_data & pwrite);
	ram_waddr = state_ff[1] ? fill_addr_ff : addr_counter_ff;
	ram_wdata = state_ff[1] ? `LCDIC_SPACE_CODE : pwdata[7:0];
end

// ----------------------------------------------------------------------
// address counter and window step
// ----------------------------------------------------------------------
always @* begin
	ac_step  = incr_dir_ff ? addr_counter_ff + ONE_AC : addr_counter_ff - ONE_AC;
	win_step = incr_dir_ff ? window_ofs + ONE_AC : window_ofs - ONE_AC;
end

lcdic_busy_timer #(
	.CW       (CW)
) u_busy (
	.pclk     (pclk),
	.presetn  (presetn),
	.clk_en   (clk_en),
	.start    (timer_start),
	.load_val (timer_load),
	.busy     (busy_cnt)
);

lcdic_text_ram #(
	.AW       (ACW),
	.DW       (8)
) u_ram (
	.pclk     (pclk),
	.clk_en   (clk_en),
	.we       (ram_we),
	.waddr    (ram_waddr),
	.wdata    (ram_wdata),
	.raddr    (addr_counter_ff),
	.rdata_ff (ram_rdata)
);

// ----------------------------------------------------------------------
// apb answer: one wait cycle per access
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= 32'h0000_0000;
	end else if (clk_en) begin
		// refused accesses are still answered, only their effect is dropped
		pready  <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & ~addr_ok;
		if (psel && penable && !pready && !pwrite) begin
			prdata <= nxt_rdata;
		end
	end
end

// ----------------------------------------------------------------------
// instruction interpreter
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_ff                <= ST_IDLE;
		fill_addr_ff            <= {ACW{1'b0}};
		addr_counter_ff         <= `LCDIC_RST_AC;
		incr_dir_ff             <= `LCDIC_RST_INCR;
		shift_en_ff             <= `LCDIC_RST_SHIFT;
		disp_on                 <= `LCDIC_RST_DISP;
		cursor_on               <= `LCDIC_RST_CURSOR;
		blink_on                <= `LCDIC_RST_BLINK;
		bus_width_select_ff     <= `LCDIC_RST_WIDTH;
		ext_set_select_ff       <= `LCDIC_RST_EXT;
		scroll_target_select_ff <= `LCDIC_RST_SCROLL;
		invert_sel_ff           <= `LCDIC_RST_INVSEL;
		inverted_lines          <= `LCDIC_RST_INVLN;
		awake                   <= `LCDIC_RST_AWAKE;
		graphic_on              <= `LCDIC_RST_GRAPH;
		window_ofs              <= {ACW{1'b0}};
	end else if (clk_en) begin
		case (state_ff)
		ST_FILL: begin
			fill_addr_ff <= fill_addr_ff + ONE_AC;
			if (fill_addr_ff == {ACW{1'b1}}) begin
				state_ff <= ST_IDLE;
			end
		end
		ST_IDLE: begin
			if (accept_data) begin
				addr_counter_ff <= ac_step;
				if (shift_en_ff) begin
					window_ofs <= win_step;
				end
			end
			if (accept_instr) begin
				if (ins[7]) begin
					addr_counter_ff <= ins[ACW-1:0];
				end else if (ins[6]) begin
					addr_counter_ff <= {1'b0, ins[5:0]};
				end else if (ins[5]) begin
					bus_width_select_ff <= ins[4];
					ext_set_select_ff   <= ins[2];
					if (ext_set_select_ff) begin
						graphic_on <= ins[1];
					end
				end else if (ins[4]) begin
					addr_counter_ff <= addr_counter_ff;
				end else if (ins[3]) begin
					if (ext_set_select_ff) begin
						awake <= ins[2];
					end else begin
						disp_on   <= ins[2];
						cursor_on <= ins[1];
						blink_on  <= ins[0];
					end
				end else if (ins[2]) begin
					if (ext_set_select_ff) begin
						invert_sel_ff <= ins[1:0];
						inverted_lines[ins[1:0]] <= ~inverted_lines[ins[1:0]];
					end else if (is_entry) begin
						incr_dir_ff <= ins[1];
						shift_en_ff <= ins[0];
					end
				end else if (ins[1]) begin
					if (ext_set_select_ff) begin
						scroll_target_select_ff <= ins[0];
					end else if (is_home) begin
						addr_counter_ff <= `LCDIC_HOME_AC;
					end
				end else if (is_clear) begin
					addr_counter_ff <= `LCDIC_HOME_AC;
					incr_dir_ff     <= 1'b1;
					fill_addr_ff    <= {ACW{1'b0}};
					state_ff        <= ST_FILL;
				end
			end
		end
		default: begin
			state_ff <= ST_IDLE;
		end
		endcase
	end
end

endmodule

//--- tb/lcdic_core_sva.sv
// lcdic_core_sva.sv - port checker for the display instruction core
// assumes: bound to lcdic_core, one clock pclk, async active-low presetn
`timescale 1ns/10ps
module lcdic_core_chk #(
	parameter ACW = 7
) (
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pready,
	input wire logic           pslverr,
	input wire logic           disp_on,
	input wire logic           cursor_on,
	input wire logic           blink_on,
	input wire logic           graphic_on,
	input wire logic           awake,
	input wire logic [3:0]     inverted_lines,
	input wire logic [ACW-1:0] window_ofs
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	property p_answer;
		s_setup ##1 s_access |-> !pready ##1 pready;
	endproperty
	a_answer: assert property (p_answer) else $error("answer not in second access cycle");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	// ------------------------------------------------------------
	// reset state
	// ------------------------------------------------------------
	property p_rst_ctrl;
		$rose(presetn) |-> !disp_on && !cursor_on && !blink_on;
	endproperty
	a_rst_ctrl: assert property (p_rst_ctrl) else $error("display bits set after reset");
	property p_rst_ext;
		$rose(presetn) |-> awake && !graphic_on;
	endproperty
	a_rst_ext: assert property (p_rst_ext) else $error("awake or graphic wrong after reset");
	property p_rst_inv;
		$rose(presetn) |-> inverted_lines == 4'h0;
	endproperty
	a_rst_inv: assert property (p_rst_inv) else $error("lines inverted after reset");
	property p_rst_win;
		$rose(presetn) |-> window_ofs == '0;
	endproperty
	a_rst_win: assert property (p_rst_win) else $error("window moved after reset");
	// ------------------------------------------------------------
	// state moves only after an answered access
	// ------------------------------------------------------------
	property p_win_cause;
		$changed(window_ofs) |-> $past(pready) || $past(pready, 2);
	endproperty
	a_win_cause: assert property (p_win_cause) else $error("window moved unasked");
	property p_ctrl_cause;
		$changed(disp_on) |-> $past(pready) || $past(pready, 2);
	endproperty
	a_ctrl_cause: assert property (p_ctrl_cause) else $error("display bit moved unasked");
endmodule
bind lcdic_core lcdic_core_chk #(.ACW(ACW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .disp_on(disp_on),
	.cursor_on(cursor_on), .blink_on(blink_on), .graphic_on(graphic_on), .awake(awake),
	.inverted_lines(inverted_lines), .window_ofs(window_ofs));

//--- tb/lcdic_host.sv
// lcdic_host.sv - host processor model, apb master with pending-flag polling
// assumes: status at 0x8 with pending flag on bit 7, instructions at 0x0
`timescale 1ns/10ps
module lcdic_host (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel = 1'b0,
	output logic             penable = 1'b0,
	output logic             pwrite = 1'b0,
	output logic [11:0]      paddr = 12'h0,
	output logic [31:0]      pwdata = 32'h0
);
	// one transfer, held until ready; returns once the answer edge has settled
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(negedge pclk);
	endtask
	task automatic idle();
		logic [31:0] rd;
		logic        e;
		do xfer(1'b0, 12'h008, 32'h0, rd, e); while (rd[7] !== 1'b0);
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		logic e;
		idle();
		xfer(w, a, d, rd, e);
	endtask
endmodule

//--- tb/lcd_instr_defaults_and_cursor_cmds_tb.sv
// lcd_instr_defaults_and_cursor_cmds_tb.sv - self-checking bench of lcdic_core
// assumes: short execution counts, host model drives the apb side
`timescale 1ns/10ps
module lcd_instr_defaults_and_cursor_cmds_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic        disp_on, cursor_on, blink_on, graphic_on, awake, e;
	logic [3:0]  inverted_lines;
	logic [6:0]  window_ofs;
	int          err_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	localparam int CLR_CYC   = 200;
	localparam int SHORT_CYC = 8;
	initial forever #2.5 pclk = ~pclk;
	lcdic_host h (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	lcdic_core #(.CYC_CLEAR(CLR_CYC), .CYC_SHORT(SHORT_CYC)) dut (.pclk(pclk), .presetn(presetn),
		.clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.disp_on(disp_on), .cursor_on(cursor_on), .blink_on(blink_on),
		.graphic_on(graphic_on), .awake(awake), .inverted_lines(inverted_lines),
		.window_ofs(window_ofs));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		h.acc(1'b1, 12'h000, {24'h0, c}, v);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		h.acc(1'b0, 12'h00c, 32'h0, v);
		check(v, 32'h142);
		h.acc(1'b0, 12'h008, 32'h0, v);
		check(v, 32'h0);
		check({disp_on, cursor_on, blink_on, graphic_on, awake, inverted_lines, window_ofs},
			32'h800);
	endtask
	task automatic t_clear();
		cmd(8'h04);
		cmd(8'h01);
		h.acc(1'b0, 12'h00c, 32'h0, v);
		check(v[1], 1'b1);
		h.acc(1'b0, 12'h004, 32'h0, v);
		check(v, 32'h20);
		h.acc(1'b0, 12'h008, 32'h0, v);
		check(v, 32'h1);
	endtask
	task automatic t_entry();
		cmd(8'h02);
		cmd(8'h07);
		h.acc(1'b1, 12'h004, 32'h41, v);
		h.acc(1'b1, 12'h004, 32'h42, v);
		h.acc(1'b0, 12'h008, 32'h0, v);
		check(v, 32'h2);
		check(window_ofs, 32'h2);
		cmd(8'h05);
		h.acc(1'b1, 12'h004, 32'h43, v);
		check(window_ofs, 32'h1);
		cmd(8'h04);
		h.acc(1'b0, 12'h004, 32'h0, v);
		check(v, 32'h42);
		check(window_ofs, 32'h1);
		h.acc(1'b0, 12'h008, 32'h0, v);
		check(v, 32'h0);
	endtask
	task automatic t_home();
		cmd(8'h06);
		h.acc(1'b0, 12'h004, 32'h0, v);
		check(v, 32'h41);
		cmd(8'h02);
		h.acc(1'b0, 12'h008, 32'h0, v);
		check(v, 32'h0);
		h.acc(1'b0, 12'h004, 32'h0, v);
		check(v, 32'h41);
	endtask
	task automatic t_busy();
		cmd(8'h0c);
		h.xfer(1'b0, 12'h008, 32'h0, v, e);
		check(v[7], 1'b1);
		h.xfer(1'b1, 12'h000, 32'h08, v, e);
		h.idle();
		check({disp_on, cursor_on, blink_on}, 32'h4);
	endtask
	task automatic t_ext();
		cmd(8'h34);
		cmd(8'h08);
		check(awake, 1'b0);
		cmd(8'h0c);
		check(awake, 1'b1);
		cmd(8'h04);
		check(inverted_lines, 32'h1);
		cmd(8'h07);
		check(inverted_lines, 32'h9);
		cmd(8'h36);
		check(graphic_on, 1'b1);
		cmd(8'h30);
		h.acc(1'b0, 12'h00c, 32'h0, v);
		check(v[5], 1'b0);
		h.xfer(1'b0, 12'h010, 32'h0, v, e);
		check(e, 1'b1);
		check(v, 32'h0);
	endtask
	// one status poll takes four cycles
	task automatic t_time();
		int n;
		cmd(8'h01);
		n = 0;
		do begin
			h.xfer(1'b0, 12'h008, 32'h0, v, e);
			n++;
		end while (v[7] === 1'b1 && n < 100);
		check(n >= CLR_CYC / 4 && n <= CLR_CYC / 4 + 2, 1'b1);
		cmd(8'h06);
		n = 0;
		do begin
			h.xfer(1'b0, 12'h008, 32'h0, v, e);
			n++;
		end while (v[7] === 1'b1 && n < 100);
		check(n >= SHORT_CYC / 4 && n <= SHORT_CYC / 4 + 2, 1'b1);
		cmd(8'hff);
		h.acc(1'b0, 12'h004, 32'h0, v);
		check(v, 32'h20);
		h.acc(1'b0, 12'h008, 32'h0, v);
		check(v, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_clear();
		t_entry();
		t_home();
		t_busy();
		t_ext();
		t_time();
		complete_run();
	end
endmodule
